// ---- adps_address_decode.sv ----
// Core address decoder, select generation and program page window logic
`timescale 1ns/1ns
`default_nettype none

module adps_address_decode #(
   parameter logic [9:0] REG_IMPL_END = adps_pkg::REG_OFF_IMPL_END,
   parameter logic [5:0] PAGE_INIT    = adps_pkg::PAGE_RESET
) (
   input  wire logic                    i_clock,
   input  wire logic                    i_rst,
   input  wire logic                    i_clk_en,
   input  wire adps_pkg::adps_req_s     i_req,
   input  wire adps_pkg::adps_mode_e    i_mode,
   input  wire logic                    i_bdm_hit,
   input  wire logic [5:0]              i_reg_base,
   input  wire logic [1:0]              i_ram_base,
   input  wire logic                    i_ram_en,
   input  wire logic [3:0]              i_eep_base,
   input  wire logic                    i_eep_en,
   input  wire logic [1:0]              i_rom_alloc,
   input  wire logic                    i_rom_hide,
   input  wire logic [1:0]              i_paging_partition_straps,
   input  wire logic                    i_port_e_emulation_enable,
   input  wire logic                    i_port_k_emulation_enable,
   input  wire logic                    i_page_wr_allowed,
   input  wire logic                    i_far_wr,
   input  wire logic [5:0]              i_far_page,
   input  wire logic [7:0]              i_port_k_gpio,
   input  wire logic                    i_swap,
   input  wire logic [15:0]             i_rdata_bdm,
   input  wire logic [15:0]             i_rdata_regs,
   input  wire logic [15:0]             i_rdata_ram,
   input  wire logic [15:0]             i_rdata_eep,
   input  wire logic [15:0]             i_rdata_flash,
   input  wire logic [15:0]             i_rdata_ext,
   output var adps_pkg::adps_sel_s      o_sel,
   output logic                         o_reg_removed,
   output logic [7:0]                   o_port_k,
   output logic [5:0]                   o_extended_address_high,
   output logic [5:0]                   o_page_index_bits,
   output logic                         o_page_internal,
   output logic [15:0]                  o_rdata
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Modes in which the external bus is live
   function automatic logic is_expanded(input adps_pkg::adps_mode_e m);
      is_expanded = (m == adps_pkg::ADPS_MODE_NORMAL_EXPANDED) ||
                    (m == adps_pkg::ADPS_MODE_EMUL_EXPANDED) ||
                    (m == adps_pkg::ADPS_MODE_SPECIAL_EXPANDED);
   endfunction

   // Only the emulation expanded mode may drive the emulation select
   function automatic logic is_emulation(input adps_pkg::adps_mode_e m);
      is_emulation = (m == adps_pkg::ADPS_MODE_EMUL_EXPANDED);
   endfunction

   // Page window access internal for the strap partitioning
   // Code 11 puts every page on chip, so no threshold applies
   function automatic logic page_is_internal(input logic [1:0] straps,
                                             input logic [5:0] page);
      unique case (straps)
         2'h0:    page_is_internal = (page >= adps_pkg::PAGE_THR_128K);
         2'h1:    page_is_internal = (page >= adps_pkg::PAGE_THR_256K);
         2'h2:    page_is_internal = (page >= adps_pkg::PAGE_THR_512K);
         default: page_is_internal = 1'b1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser

   // Straps come from the core boundary, so two flops before use
   // They are static after power-up, so the two-edge lag is harmless;
   // until it ends the window decodes as the smallest on-chip share
   logic [1:0] strap_meta_q;
   logic [1:0] strap_meta_d;
   logic [1:0] strap_q;
   logic [1:0] strap_d;

   always_comb
   begin
      strap_meta_d = i_paging_partition_straps;
      strap_d      = strap_meta_q;
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         strap_meta_q <= 2'h0;
         strap_q      <= 2'h0;
      end
      else if (i_clk_en)
      begin
         strap_meta_q <= strap_meta_d;
         strap_q      <= strap_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address classification

   logic [1:0] qtr;
   logic [9:0] reg_off;
   logic       reg_hit;
   logic       reg_unimpl;
   logic       reg_removed;
   logic       ram_hit;
   logic       eep_hit;
   logic       flash_hit;
   logic       in_window;
   logic       win_internal;
   logic       expanded;
   logic       emul;
   logic       emk_live;
   logic [5:0] page_q;
   logic [5:0] page_d;
   logic       page_wr;

   always_comb
   begin
      qtr       = i_req.addr[15:14];
      reg_off   = i_req.addr[9:0];
      expanded  = is_expanded(i_mode);
      emul      = is_emulation(i_mode);
      // Port K pins carry bus signals only in an expanded mode
      emk_live  = i_port_k_emulation_enable && expanded;
      in_window = (qtr == adps_pkg::QTR_WINDOW);
      win_internal = page_is_internal(strap_q, page_q);
      // Decode is purely from the live address, no history
      reg_hit   = (i_req.addr[15:10] == i_reg_base);
      // Offsets past the implemented end still select the register block
      reg_unimpl = (reg_off >= REG_IMPL_END);
      // Bus expansion registers leave the map per mode
      //   0x000-0x003 ports A and B, any expanded mode
      //   0x008-0x009 port E, expanded with its emulation bit
      //   0x000-0x00f whole expansion group, special peripheral
      //   0x032-0x033 port K, emulation with its emulation bit
      reg_removed = (expanded && (reg_off <= adps_pkg::REG_OFF_B_LAST))
         || (expanded && i_port_e_emulation_enable &&
             ((reg_off == adps_pkg::REG_OFF_E_DATA) ||
              (reg_off == adps_pkg::REG_OFF_E_DIR)))
         || ((i_mode == adps_pkg::ADPS_MODE_SPECIAL_PERIPHERAL) &&
             (reg_off <= adps_pkg::REG_OFF_EXP_LAST))
         || (emul && i_port_k_emulation_enable &&
             ((reg_off == adps_pkg::REG_OFF_K_DATA) ||
              (reg_off == adps_pkg::REG_OFF_K_DIR)));
      // RAM claims a quarter and EEPROM a 4K block when enabled
      ram_hit   = i_ram_en && (qtr == i_ram_base);
      eep_hit   = i_eep_en && (i_req.addr[15:12] == i_eep_base);
      // Flash: top quarter always unpaged, window only for internal pages
      unique case (qtr)
         adps_pkg::QTR_TOP:    flash_hit = (i_rom_alloc != adps_pkg::ROM_ALLOC_0K);
         adps_pkg::QTR_WINDOW: flash_hit = (i_rom_alloc != adps_pkg::ROM_ALLOC_0K) &&
                                           win_internal;
         adps_pkg::QTR_MID:    flash_hit = (i_rom_alloc > adps_pkg::ROM_ALLOC_16K) &&
                                           !i_rom_hide;
         default:              flash_hit = (i_rom_alloc == adps_pkg::ROM_ALLOC_64K) &&
                                           !i_rom_hide;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority select

   // A chain of else-ifs keeps the group one-hot by construction
   // Order: debug, registers, removed registers, RAM, EEPROM, flash, bus
   // RAM moved onto the register block loses the overlapped part
   adps_pkg::adps_sel_s sel_d;
   logic                removed_d;

   always_comb
   begin
      sel_d     = '0;
      removed_d = 1'b0;
      if (i_bdm_hit)
         sel_d.background_debug_space = 1'b1;
      else if (reg_hit && !reg_removed)
         sel_d.regs = 1'b1;
      else if (reg_hit)
      begin
         // Removed register: goes out on the bus in expanded modes, but without a chip select
         sel_d.ext = expanded;
         removed_d = 1'b1;
      end
      else if (ram_hit)
         sel_d.ram = 1'b1;
      else if (eep_hit)
         sel_d.eep = 1'b1;
      else if (flash_hit)
         sel_d.flash = 1'b1;
      else if (expanded)
         sel_d.ext = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Chip selects and extended address

   logic       ecs_act;
   logic       xcs_act;
   logic [5:0] xaddr_d;
   logic [7:0] port_k_d;

   always_comb
   begin
      // Both chip selects are active low on the pins; the internal
      // flags are active high and inverted only at port K
      // Emulation select follows the allocation table per quarter
      unique case (qtr)
         adps_pkg::QTR_TOP:    ecs_act = 1'b1;
         adps_pkg::QTR_WINDOW: ecs_act = (i_rom_alloc == adps_pkg::ROM_ALLOC_0K) ||
                                         ((i_rom_alloc != adps_pkg::ROM_ALLOC_16K) &&
                                          win_internal);
         adps_pkg::QTR_MID:    ecs_act = (i_rom_alloc > adps_pkg::ROM_ALLOC_16K) &&
                                         !i_rom_hide;
         default:              ecs_act = (i_rom_alloc == adps_pkg::ROM_ALLOC_64K) &&
                                         !i_rom_hide;
      endcase
      // Higher selects shadow flash space
      ecs_act = ecs_act && emul && emk_live && !i_bdm_hit &&
                !reg_hit && !ram_hit && !eep_hit;
      // Removed registers reach the bus with no select; unimplemented ones keep the register select
      xcs_act = emk_live && !ecs_act && sel_d.ext &&
                !removed_d && !(reg_hit && reg_unimpl);
      // Window shows the page; fixed quarters get constant high lines
      unique case (qtr)
         adps_pkg::QTR_TOP:    xaddr_d = adps_pkg::XADDR_TOP;
         adps_pkg::QTR_WINDOW: xaddr_d = page_q;
         adps_pkg::QTR_MID:    xaddr_d = adps_pkg::XADDR_MID;
         default:              xaddr_d = adps_pkg::XADDR_LOW;
      endcase
      if (!emk_live)
         xaddr_d = 6'h00;
      // Port K pins: GPIO unless the emulation bit claims them
      // Bits 5:0 then carry the extended address lines
      port_k_d = i_port_k_gpio;
      if (i_port_k_emulation_enable)
      begin
         port_k_d[5:0]                    = xaddr_d;
         port_k_d[adps_pkg::PORT_K_ECS_BIT] = !ecs_act;
         port_k_d[adps_pkg::PORT_K_XCS_BIT] = !xcs_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Page index register

   // Far call updates win over a bus write landing in the same cycle,
   // since the instruction owns the bus during its page switch
   // A bus write lands at the edge it is seen and steers the window
   // from the next cycle; the copy on the output port lags once more

   always_comb
   begin
      page_wr = i_req.wr && reg_hit && !reg_removed &&
                (reg_off == adps_pkg::REG_OFF_PAGE) && i_page_wr_allowed;
      page_d  = page_q;
      if (i_far_wr)
         page_d = i_far_page;
      else if (page_wr)
         page_d = i_req.wdata[5:0];
   end

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         page_q <= PAGE_INIT;
      else if (i_clk_en)
         page_q <= page_d;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data path

   logic [15:0] rd_mux;
   logic [15:0] rdata_d;

   // Sources follow the select priority, so the mux needs no one-hot
   // check of its own; nothing selected reads as zero
   always_comb
   begin
      rd_mux = 16'h0000;
      if (sel_d.background_debug_space)
         rd_mux = i_rdata_bdm;
      else if (sel_d.regs && (reg_off == adps_pkg::REG_OFF_PAGE))
         rd_mux = {8'h00, 2'h0, page_q};
      else if (sel_d.regs)
         rd_mux = i_rdata_regs;
      else if (sel_d.ram)
         rd_mux = i_rdata_ram;
      else if (sel_d.eep)
         rd_mux = i_rdata_eep;
      else if (sel_d.flash)
         rd_mux = i_rdata_flash;
      else if (sel_d.ext)
         rd_mux = i_rdata_ext;
      // Odd-byte accesses need the halves exchanged for the core
      rdata_d = i_swap ? {rd_mux[7:0], rd_mux[15:8]} : rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output registers

   // Window flag for the output stage, kept out of the flop process
   logic pint_d;

   always_comb
   begin
      pint_d = in_window && win_internal;
   end

   // Outputs are flopped to give clean pins; decode is one cycle ahead
   // Trade-off: pins are glitch free, but the core sees its selects a
   // cycle late and must allow for that in its access timing
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_sel                   <= '0;
         o_reg_removed           <= 1'b0;
         o_port_k                <= 8'h00;
         o_extended_address_high <= 6'h00;
         o_page_index_bits       <= PAGE_INIT;
         o_page_internal         <= 1'b0;
         o_rdata                 <= 16'h0000;
      end
      else if (i_clk_en)
      begin
         o_sel                   <= sel_d;
         o_reg_removed           <= removed_d;
         o_port_k                <= port_k_d;
         o_extended_address_high <= xaddr_d;
         o_page_index_bits       <= page_q;
         o_page_internal         <= pint_d;
         o_rdata                 <= rdata_d;
      end
   end

endmodule // adps_address_decode

`default_nettype wire

// ---- adps_pkg.sv ----
// Package of constants and types for the address decode and page select block
package adps_pkg;

   typedef enum logic [2:0] {
      ADPS_MODE_SINGLE,
      ADPS_MODE_NORMAL_EXPANDED,
      ADPS_MODE_EMUL_EXPANDED,
      ADPS_MODE_SPECIAL_SINGLE,
      ADPS_MODE_SPECIAL_PERIPHERAL,
      ADPS_MODE_SPECIAL_EXPANDED
   } adps_mode_e;

   // Core bus request
   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } adps_req_s;

   // One-hot select group
   typedef struct packed {
      logic background_debug_space;
      logic regs;
      logic ram;
      logic eep;
      logic flash;
      logic ext;
   } adps_sel_s;

   localparam logic [9:0]  REG_OFF_B_LAST    = 10'h003;
   localparam logic [9:0]  REG_OFF_E_DATA    = 10'h008;
   localparam logic [9:0]  REG_OFF_E_DIR     = 10'h009;
   localparam logic [9:0]  REG_OFF_EXP_LAST  = 10'h00f;
   localparam logic [9:0]  REG_OFF_K_DATA    = 10'h032;
   localparam logic [9:0]  REG_OFF_K_DIR     = 10'h033;
   localparam logic [9:0]  REG_OFF_PAGE      = 10'h030;
   localparam logic [9:0]  REG_OFF_IMPL_END  = 10'h380;
   localparam logic [5:0]  PAGE_RESET        = 6'h00;
   localparam logic [5:0]  PAGE_THR_128K     = 6'h38;
   localparam logic [5:0]  PAGE_THR_256K     = 6'h30;
   localparam logic [5:0]  PAGE_THR_512K     = 6'h20;
   localparam logic [1:0]  QTR_LOW           = 2'h0;
   localparam logic [1:0]  QTR_MID           = 2'h1;
   localparam logic [1:0]  QTR_WINDOW        = 2'h2;
   localparam logic [1:0]  QTR_TOP           = 2'h3;
   localparam logic [5:0]  XADDR_LOW         = 6'h3d;
   localparam logic [5:0]  XADDR_MID         = 6'h3e;
   localparam logic [5:0]  XADDR_TOP         = 6'h3f;
   localparam logic [1:0]  ROM_ALLOC_0K      = 2'h0;
   localparam logic [1:0]  ROM_ALLOC_16K     = 2'h1;
   localparam logic [1:0]  ROM_ALLOC_64K     = 2'h3;
   localparam int          PORT_K_ECS_BIT    = 7;
   localparam int          PORT_K_XCS_BIT    = 6;

endpackage : adps_pkg

// ---- adps_decode_monitor.sv ----
// Checker of selects, chip selects and page window behaviour at the decoder ports
`timescale 1ns/1ns
`default_nettype none

module adps_decode_monitor (
   input wire logic                 i_clock,
   input wire logic                 i_rst,
   input wire adps_pkg::adps_req_s  i_req,
   input wire adps_pkg::adps_mode_e i_mode,
   input wire logic [1:0]           i_paging_partition_straps,
   input wire logic                 i_port_k_emulation_enable,
   input wire logic                 i_far_wr,
   input wire logic [5:0]           i_far_page,
   input wire logic [7:0]           i_port_k_gpio,
   input wire adps_pkg::adps_sel_s  o_sel,
   input wire logic                 o_reg_removed,
   input wire logic [7:0]           o_port_k,
   input wire logic [5:0]           o_extended_address_high,
   input wire logic [5:0]           o_page_index_bits,
   input wire logic                 o_page_internal
);
   logic [2:0] live_q;
   logic       xp_c;
   logic       emu_c;
   logic       pk_c;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Mode classes of the cycle being decoded
   assign xp_c  = i_mode inside {adps_pkg::ADPS_MODE_NORMAL_EXPANDED, adps_pkg::ADPS_MODE_EMUL_EXPANDED,
                                 adps_pkg::ADPS_MODE_SPECIAL_EXPANDED};
   assign emu_c = i_mode == adps_pkg::ADPS_MODE_EMUL_EXPANDED;
   assign pk_c  = i_port_k_emulation_enable;

   // Edges since reset: outputs seen at the first edge still belong to the reset
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         live_q <= 3'h0;
      else if (live_q != 3'h7)
         live_q <= live_q + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   sel_onehot_a: assert property ($onehot0(o_sel))
      else $error("more than one select active");
   ext_mode_a: assert property (o_sel.ext |-> live_q != 3'h0 && $past(xp_c))
      else $error("external select outside expanded mode");
   port_gpio_a: assert property (live_q != 3'h0 && !$past(pk_c) |-> o_port_k == $past(i_port_k_gpio))
      else $error("port k not passing general purpose values");
   emul_cs_mode_a: assert property (live_q != 3'h0 && $past(pk_c) && !$past(emu_c) |-> o_port_k[7])
      else $error("emulation select active outside emulation mode");
   ext_cs_excl_a: assert property (live_q != 3'h0 && $past(pk_c) && !o_port_k[6]
      |-> o_port_k[7] && o_sel.ext && !o_reg_removed && $past(xp_c))
      else $error("external select active without an external access");
   top_xaddr_a: assert property (live_q != 3'h0 && $past(pk_c && xp_c && i_req.addr[15:14] == 2'h3)
      |-> o_extended_address_high == 6'h3f)
      else $error("top region extended address wrong");
   window_only_a: assert property (o_page_internal |-> live_q != 3'h0 && $past(i_req.addr[15:14]) == 2'h2)
      else $error("page internal flag outside the window");
   far_page_a: assert property (i_far_wr |-> ##2 o_page_index_bits == $past(i_far_page, 2))
      else $error("far page load not seen");
   full_share_a: assert property (live_q == 3'h7 && $past(i_paging_partition_straps, 3) == 2'h3
      && $past(i_req.addr[15:14]) == 2'h2 |-> o_page_internal)
      else $error("full on-chip share gave an external page");

   // Main scenarios reached
   emul_cs_c: cover property (live_q != 3'h0 && $past(pk_c) && !o_port_k[7]);
   ext_cs_c: cover property (live_q != 3'h0 && $past(pk_c) && !o_port_k[6]);
   window_c: cover property (o_page_internal);
   removed_c: cover property (o_reg_removed && o_sel.ext);

endmodule // adps_decode_monitor

bind adps_address_decode adps_decode_monitor mon_u (.i_clock, .i_rst, .i_req, .i_mode, .i_paging_partition_straps,
   .i_port_k_emulation_enable, .i_far_wr, .i_far_page, .i_port_k_gpio, .o_sel, .o_reg_removed, .o_port_k,
   .o_extended_address_high, .o_page_index_bits, .o_page_internal);
`default_nettype wire

// ---- adps_core_partner.sv ----
// Far-side model: read data sources of the six core bus resources
`timescale 1ns/1ns
`default_nettype none

module adps_core_partner (
   input  wire logic       i_clock,
   output logic [5:0][15:0] o_rdata
);
   logic [15:0] lfsr_q = 16'hace1;

   // Fresh words every cycle, so a stale or wrong mux path cannot match by chance
   always @(posedge i_clock)
   begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
   end

   // Each source differs from the others in its top nibble
   always_comb
   begin
      for (int i = 0; i < 6; i++)
         o_rdata[i] = lfsr_q ^ {4'(i), 12'h5a3};
   end
endmodule // adps_core_partner
`default_nettype wire

// ---- tb_address_decode_page_select.sv ----
// Self-checking bench of the address decoder with random and corner stimulus
`timescale 1ns/1ns
`default_nettype none

module tb_address_decode_page_select;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   adps_pkg::adps_req_s  req = '0;
   adps_pkg::adps_mode_e mode = adps_pkg::ADPS_MODE_SINGLE;
   logic                 dbg_hit = 1'b0, ram_en = 1'b0, eep_en = 1'b0, hide = 1'b0, pe = 1'b0, pk = 1'b0;
   logic                 wr_ok = 1'b0, far_wr = 1'b0, swap = 1'b0;
   logic [5:0]           reg_base = 6'h00, far_page = 6'h00, e_xa, e_pib, pg_m, xah, pib;
   logic [1:0]           ram_base = 2'h0, alloc = 2'h0, straps = 2'h0, s1_m, s2_m;
   logic [3:0]           eep_base = 4'h0;
   logic [7:0]           gpio = 8'h00, e_gp, pko;
   logic [5:0][15:0]     rd;
   logic [5:0]           e_sel;
   logic [15:0]          e_rd, rdo;
   logic                 e_rem, e_pint, e_emcs, e_excs, e_pk, e_xp, rd_chk, removed, pint;
   logic                 armed = 1'b0;
   adps_pkg::adps_sel_s  sel;
   int                   bad_count = 0;
   int                   comparisons = 0;
   int                   cycles = 0;

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic stop_test();
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Page window internal for a strap code and page index
   function automatic logic exp_internal(input logic [1:0] sw, input logic [5:0] pg);
      return sw == 2'h3 || pg >= (sw == 2'h0 ? 6'h38 : sw == 2'h1 ? 6'h30 : 6'h20);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   always #25 clk = ~clk;

   adps_core_partner far_u (.i_clock(clk), .o_rdata(rd));

   adps_address_decode dut_u (.i_clock(clk), .i_rst(rst), .i_clk_en(1'b1), .i_req(req), .i_mode(mode),
      .i_bdm_hit(dbg_hit), .i_reg_base(reg_base), .i_ram_base(ram_base), .i_ram_en(ram_en), .i_eep_base(eep_base),
      .i_eep_en(eep_en), .i_rom_alloc(alloc), .i_rom_hide(hide), .i_paging_partition_straps(straps),
      .i_port_e_emulation_enable(pe), .i_port_k_emulation_enable(pk), .i_page_wr_allowed(wr_ok), .i_far_wr(far_wr),
      .i_far_page(far_page), .i_port_k_gpio(gpio), .i_swap(swap), .i_rdata_bdm(rd[0]), .i_rdata_regs(rd[1]),
      .i_rdata_ram(rd[2]), .i_rdata_eep(rd[3]), .i_rdata_flash(rd[4]), .i_rdata_ext(rd[5]), .o_sel(sel),
      .o_reg_removed(removed), .o_port_k(pko), .o_extended_address_high(xah), .o_page_index_bits(pib),
      .o_page_internal(pint), .o_rdata(rdo));

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Reference decode of the inputs the design samples at this edge
   always @(posedge clk)
   begin : model
      logic [9:0]  off;
      logic [1:0]  q;
      logic        xp, emu, pi, rh, rm, ram, eep, fl, cs;
      logic [5:0]  s;
      logic [15:0] d;
      off = req.addr[9:0];
      q = req.addr[15:14];
      xp = mode inside {adps_pkg::ADPS_MODE_NORMAL_EXPANDED, adps_pkg::ADPS_MODE_EMUL_EXPANDED,
                        adps_pkg::ADPS_MODE_SPECIAL_EXPANDED};
      emu = mode == adps_pkg::ADPS_MODE_EMUL_EXPANDED;
      pi = exp_internal(s2_m, pg_m);
      rh = req.addr[15:10] == reg_base;
      rm = rh && ((xp && off <= 10'h3) || (xp && pe && off inside {10'h8, 10'h9}) || (emu && pk &&
           off inside {10'h32, 10'h33}) || (mode == adps_pkg::ADPS_MODE_SPECIAL_PERIPHERAL && off <= 10'hf));
      ram = ram_en && q == ram_base;
      eep = eep_en && req.addr[15:12] == eep_base;
      fl = alloc != 2'h0 && (q == 2'h3 || (q == 2'h2 && pi) || (q == 2'h1 && alloc[1] && !hide)
           || (q == 2'h0 && alloc == 2'h3 && !hide));
      s = dbg_hit ? 6'h20 : (rh && !rm) ? 6'h10 : rm ? {5'h0, xp} : ram ? 6'h08 : eep ? 6'h04 : fl ? 6'h02
          : {5'h0, xp};
      cs = emu && pk && !dbg_hit && !rh && !ram && !eep && (q == 2'h3 || (q == 2'h2 && (alloc == 2'h0
           || (alloc[1] && pi))) || (q == 2'h1 && alloc[1] && !hide) || (q == 2'h0 && alloc == 2'h3 && !hide));
      d = 16'h0000;
      for (int i = 0; i < 6; i++)
         if (s[5 - i])
            d = rd[i];
      if (s[4] && off == 10'h030)
         d = {10'h000, pg_m};
      e_sel <= s;
      e_rem <= rm && !dbg_hit;
      e_pint <= q == 2'h2 && pi;
      e_emcs <= cs;
      e_excs <= pk && xp && !cs && s == 6'h01 && !rm;
      e_xa <= !(pk && xp) ? 6'h00 : q == 2'h0 ? 6'h3d : q == 2'h1 ? 6'h3e : q == 2'h2 ? pg_m : 6'h3f;
      e_rd <= swap ? {d[7:0], d[15:8]} : d;
      rd_chk <= req.rd && s != 6'h00;
      {e_pk, e_xp, e_gp, e_pib} <= {pk, xp, gpio, pg_m};
      armed <= !rst;
      s1_m <= rst ? 2'h0 : straps;
      s2_m <= rst ? 2'h0 : s1_m;
      if (rst)
         pg_m <= 6'h00;
      else if (far_wr)
         pg_m <= far_page;
      else if (req.wr && rh && off == 10'h030 && wr_ok)
         pg_m <= req.wdata[5:0];
   end

   // Outputs have settled by the falling edge
   always @(negedge clk)
   begin
      if (armed)
      begin
         chk(sel === e_sel, "select group");
         chk(removed === e_rem, "removed register flag");
         chk(pint === e_pint, "page window internal flag");
         chk(xah === e_xa, "extended address");
         chk(pib === e_pib, "page index");
         chk(pko === (e_pk ? {!e_emcs, !e_excs, e_xa} : e_gp), "port k pins");
         if (e_pk && e_xp)
            chk(pko[5:0] === e_xa, "port k address");
         if (rd_chk)
            chk(rdo === e_rd, "read data");
      end
   end

   // Hang guard, well above the 6000-odd cycles of the run
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         stop_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // Random phases per mode and strap code, with a mid-run reset
   initial
   begin : main
      logic [31:0] r;
      void'($urandom(32'he1e47429));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < 6000; n++)
      begin
         @(posedge clk);
         r = $urandom;
         rst <= n == 3000;
         if (n % 400 == 0)
         begin
            mode <= adps_pkg::adps_mode_e'(3'((n / 400) % 6));
            straps <= 2'((n / 400) % 4);
            {reg_base, ram_base, eep_base} <= r[11:0];
            r = $urandom;
         end
         {ram_en, eep_en, hide, pe, pk, wr_ok, swap} <= r[6:0];
         alloc <= r[8:7];
         dbg_hit <= r[12:9] == 4'h0;
         far_wr <= r[15:13] == 3'h0;
         far_page <= r[21:16];
         gpio <= r[29:22];
         r = $urandom;
         req <= '{addr: r[27:26] == 2'h0 ? {reg_base, r[25] ? 10'(r[5:0]) : r[9:0]} : r[15:0],
                  rd: r[30], wr: r[31], wdata: r[23:16]};
      end
      // Pages either side of the smallest on-chip share, written then used back to back
      @(posedge clk);
      mode <= adps_pkg::ADPS_MODE_EMUL_EXPANDED;
      {straps, reg_base, ram_en, eep_en, dbg_hit, far_wr, pk, wr_ok, alloc} <= {2'h0, 6'h00, 4'h0, 2'h3, 2'h3};
      repeat (3) @(posedge clk);
      for (int p = 'h37; p <= 'h38; p++)
      begin
         @(posedge clk);
         req <= '{addr: 16'h0030, rd: 1'b0, wr: 1'b1, wdata: 8'(p)};
         @(posedge clk);
         req <= '{addr: 16'h8123, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
         @(posedge clk);
         req <= '{addr: 16'hfffe, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      end
      repeat (3) @(posedge clk);
      stop_test();
   end
endmodule // tb_address_decode_page_select
`default_nettype wire
